// [src/vcf_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "vcf_map.svh"

// How it works
// - Shadow bits mirror their one-time counterparts
// - Quad bit selects four-lane path, repurposes pins
// - Quad mode forces internal write protect inactive
// - Serial reads still work in quad mode
// - Quad clear refused while instruction mode set
// - Register write programs default, volatile follows
// - Any-register write changes volatile quad alone
// - Lock freezes protection bits and one-time area
// - Locked register writes ignored without error
// - Locked one-time program fails, sets error
// - Unlocked: protection, lock, one-time area writable
// - Lock cleared only by power or hardware reset
// - Software reset keeps the lock bit
// - Power-on loads lock from its default
// - Lock settable in same register write
// - Lock spares write-disable and quad bits
// - Register readable by config and any-register reads
// - Second register: any-register access, reset loads
// - Second register defaults flip only once
// - Reset loads quad bit from its default
// - Register write takes eight or sixteen data cycles
module vcf_top #(
	parameter vcf_pkg::vcf_addr_t OTP_BYTES = `VCF_OTP_BYTES,
	parameter logic QUAD_DEFAULT = `VCF_QUAD_DEF_RST,
	parameter logic FREEZE_DEFAULT = `VCF_FREEZE_D_RST,
	parameter logic [7:0] CFG2_DEFAULT = `VCF_CFG2_NV_RST
) (
	// Core clock and power-on reset
	input wire logic i_clock,
	input wire logic i_rstn,
	// Serial link, clocked by the host
	input wire logic i_link_clock,
	input wire logic i_cs_n,
	input wire logic i_si,
	output logic o_so,
	output logic o_so_oe,
	// Shared pins and hardware reset
	input wire logic i_data_line_two,
	input wire logic i_data_line_three,
	input wire logic i_hw_reset_n,
	// Software reset from the command decoder
	input wire logic i_soft_reset,
	// Mode and protection state
	output logic o_quad_mode,
	output logic o_qpi_mode,
	output logic o_wp_n_internal,
	output logic o_freeze,
	output logic [2:0] o_bp_level,
	output logic o_program_error,
	// One-time area program request
	output logic o_otp_program,
	output vcf_pkg::vcf_addr_t o_otp_addr,
	output vcf_pkg::vcf_byte_t o_otp_data
);
	import vcf_pkg::*;

	// Link side capture
	logic [6:0] lk_cnt, lk_len;
	logic [7:0] lk_cmd;
	vcf_addr_t lk_addr;
	logic [15:0] lk_dat;
	vcf_byte_t rd_byte;
	logic rd_active;

	// Core state
	logic [1:0] cs_sync, hw_sync, wp_sync, line3_sync;
	logic cs_high_q, wr_disable_nv, p_err, quad, freeze;
	logic [2:0] bp_nv, bp_vol;
	logic prot_start_otp, prot_select_otp, param_loc_otp, quad_default_nv;
	vcf_byte_t cfg2_nv, cfg2_vol;

	// Decode
	vcf_cmd_t cmd_kind;
	logic frame_end, hw_rst, soft_rst, do_regs, regs_both, do_any, area_hit;
	logic sr_nv_we, sr_v_we, cfg1_nv_we, cfg1_vol_we;
	logic cfg2_nv_we, cfg2_vol_we, quad_refused;
	vcf_byte_t sr_val, cr_val, img_stat_nv, img_stat_vol, img_cfg1_nv;
	vcf_byte_t img_cfg1_vol;

	// Bit counter; chip select high restarts it, as the clock stops then
	always_ff @(posedge i_link_clock or posedge i_cs_n) begin
		if (i_cs_n) begin
			lk_cnt <= 7'h00;
		end else if (lk_cnt != 7'h7f) begin
			lk_cnt <= lk_cnt + 7'h01;
		end
	end

	// Frame words stay put after the frame for the core to take
	always_ff @(posedge i_link_clock) begin
		lk_len <= (lk_cnt == 7'h7f) ? lk_cnt : lk_cnt + 7'h01;
		lk_dat <= {lk_dat[14:0], i_si};
		if (lk_cnt == `VCF_HDR_CFG - 7'h01) begin
			lk_cmd <= {lk_dat[6:0], i_si};
		end
		if (lk_cnt >= `VCF_ADDR_FIRST && lk_cnt <= `VCF_ADDR_LAST) begin
			lk_addr <= {lk_addr[22:0], i_si};
		end
	end

	// Read data; core bytes only change between frames
	always_comb begin
		rd_byte = 8'h00;
		rd_active = 1'b0;
		if (lk_cmd == `VCF_CMD_RD_CFG && lk_cnt >= `VCF_HDR_CFG) begin
			rd_active = 1'b1;
			rd_byte = img_cfg1_vol;
		end else if (lk_cmd == `VCF_CMD_RD_ANY && lk_cnt >= `VCF_HDR_ANY) begin
			rd_active = 1'b1;
			case (lk_addr)
				`VCF_ADDR_STAT_NV: rd_byte = img_stat_nv;
				`VCF_ADDR_CFG1_NV: rd_byte = img_cfg1_nv;
				`VCF_ADDR_CFG2_NV: rd_byte = cfg2_nv;
				`VCF_ADDR_STAT_V: rd_byte = img_stat_vol;
				`VCF_ADDR_CFG1_V: rd_byte = img_cfg1_vol;
				`VCF_ADDR_CFG2_V: rd_byte = cfg2_vol;
				default: rd_byte = 8'h00;
			endcase
		end
	end

	// Serial output on the falling edge, one line only in every mode
	always_ff @(negedge i_link_clock or posedge i_cs_n) begin
		if (i_cs_n) begin
			o_so <= 1'b0;
			o_so_oe <= 1'b0;
		end else begin
			o_so_oe <= rd_active;
			o_so <= rd_byte[3'h7 - lk_cnt[2:0]];
		end
	end

	// Pin synchronisers
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			cs_sync <= 2'h3;
			hw_sync <= 2'h3;
			wp_sync <= 2'h3;
			line3_sync <= 2'h3;
			cs_high_q <= 1'b1;
		end else begin
			cs_sync <= {cs_sync[0], i_cs_n};
			hw_sync <= {hw_sync[0], i_hw_reset_n};
			wp_sync <= {wp_sync[0], i_data_line_two};
			line3_sync <= {line3_sync[0], i_data_line_three};
			cs_high_q <= cs_sync[1];
		end
	end

	// Frame end and reset sources
	assign frame_end = cs_sync[1] & ~cs_high_q;
	assign soft_rst = i_soft_reset;
	assign hw_rst = ~hw_sync[1] | (cfg2_vol[`VCF_CR2_IO3R] & quad
		& cs_sync[1] & ~line3_sync[1]);

	// Command kind; short or long frames are dropped
	always_comb begin
		cmd_kind = CMD_NONE;
		if (lk_cmd == `VCF_CMD_WR_REGS && (lk_len == `VCF_LEN_REGS_ONE
			|| lk_len == `VCF_LEN_REGS_TWO)) begin
			cmd_kind = CMD_REGS;
		end else if (lk_cmd == `VCF_CMD_WR_ANY && lk_len == `VCF_LEN_ANY) begin
			cmd_kind = CMD_ANY;
		end else if (lk_cmd == `VCF_CMD_AREA_PGM && lk_len == `VCF_LEN_AREA) begin
			cmd_kind = CMD_AREA;
		end
	end

	// Write strobes, valid in the frame-end cycle only
	assign do_regs = frame_end & (cmd_kind == CMD_REGS);
	assign regs_both = do_regs & (lk_len == `VCF_LEN_REGS_TWO);
	assign do_any = frame_end & (cmd_kind == CMD_ANY);
	assign area_hit = frame_end & (cmd_kind == CMD_AREA)
		& (lk_addr < OTP_BYTES);
	assign sr_val = regs_both ? lk_dat[15:8] : lk_dat[7:0];
	assign cr_val = lk_dat[7:0];
	assign sr_nv_we = (do_regs & ~prot_select_otp)
		| (do_any & lk_addr == `VCF_ADDR_STAT_NV);
	assign sr_v_we = do_regs | (do_any & lk_addr == `VCF_ADDR_STAT_V);
	assign cfg1_nv_we = regs_both | (do_any & lk_addr == `VCF_ADDR_CFG1_NV);
	assign cfg1_vol_we = do_any & lk_addr == `VCF_ADDR_CFG1_V;
	assign cfg2_nv_we = do_any & lk_addr == `VCF_ADDR_CFG2_NV;
	assign cfg2_vol_we = do_any & lk_addr == `VCF_ADDR_CFG2_V;
	assign quad_refused = cfg2_vol[`VCF_CR2_QPI] & ~cr_val[`VCF_CR1_QUAD];

	// Status protection bits; write-disable is never locked
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			wr_disable_nv <= 1'b0;
			bp_nv <= `VCF_BP_RST;
			bp_vol <= `VCF_BP_RST;
		end else begin
			if (sr_nv_we) begin
				wr_disable_nv <= sr_val[`VCF_SR_SRWD];
			end
			if (cfg1_nv_we & ~freeze & cr_val[`VCF_CR1_PROT_SEL]) begin
				bp_nv <= 3'h7;
			end else if (sr_nv_we & ~freeze) begin
				bp_nv <= sr_val[`VCF_SR_BP_MSB:`VCF_SR_BP_LSB];
			end
			if (hw_rst | soft_rst) begin
				bp_vol <= bp_nv;
			end else if (sr_v_we & ~freeze) begin
				bp_vol <= sr_val[`VCF_SR_BP_MSB:`VCF_SR_BP_LSB];
			end
		end
	end

	// Program error; a failing program beats a reset clear
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			p_err <= 1'b0;
		end else if (area_hit & freeze) begin
			p_err <= 1'b1;
		end else if (hw_rst | soft_rst) begin
			p_err <= 1'b0;
		end
	end

	// One-time area request, only while unlocked
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_otp_program <= 1'b0;
			o_otp_addr <= 24'h000000;
			o_otp_data <= 8'h00;
		end else begin
			o_otp_program <= area_hit & ~freeze;
			if (area_hit) begin
				o_otp_addr <= lk_addr;
				o_otp_data <= cr_val;
			end
		end
	end

	// Nonvolatile first register; layout bits only go from 0 to 1
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			prot_start_otp <= 1'b0;
			prot_select_otp <= 1'b0;
			param_loc_otp <= 1'b0;
			quad_default_nv <= QUAD_DEFAULT;
		end else begin
			if (cfg2_nv_we & cr_val[`VCF_CR2_QPI]) begin
				quad_default_nv <= 1'b1;
			end else if (cfg1_nv_we & ~quad_refused) begin
				quad_default_nv <= cr_val[`VCF_CR1_QUAD];
			end
			if (cfg1_nv_we & ~freeze) begin
				prot_start_otp <= prot_start_otp | cr_val[`VCF_CR1_PROT_START];
				prot_select_otp <= prot_select_otp | cr_val[`VCF_CR1_PROT_SEL];
				param_loc_otp <= param_loc_otp | cr_val[`VCF_CR1_PARAM_LOC];
			end
		end
	end

	// Volatile quad and lock bits
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			quad <= QUAD_DEFAULT;
			freeze <= FREEZE_DEFAULT;
		end else if (hw_rst) begin
			quad <= quad_default_nv;
			freeze <= FREEZE_DEFAULT;
		end else if (soft_rst) begin
			quad <= quad_default_nv;
		end else if (regs_both | cfg1_vol_we) begin
			if (!quad_refused) begin
				quad <= cr_val[`VCF_CR1_QUAD];
			end
			freeze <= freeze | cr_val[`VCF_CR1_FREEZE];
		end
	end

	// Second register; each default may flip once only
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			cfg2_nv <= CFG2_DEFAULT;
			cfg2_vol <= CFG2_DEFAULT;
		end else begin
			if (cfg2_nv_we) begin
				cfg2_nv <= cfg2_nv ^ (~(cfg2_nv ^ CFG2_DEFAULT)
					& (cr_val ^ CFG2_DEFAULT) & `VCF_CR2_MASK);
			end
			if (hw_rst | soft_rst) begin
				cfg2_vol <= cfg2_nv;
			end else if (cfg2_vol_we) begin
				cfg2_vol <= cr_val & `VCF_CR2_MASK;
			end
		end
	end

	// Readback images; reserved bits read zero
	assign img_stat_nv = {wr_disable_nv, 2'h0, bp_nv, 2'h0};
	assign img_stat_vol = {1'b0, p_err, 1'b0, bp_vol, 2'h0};
	assign img_cfg1_nv = {2'h0, prot_start_otp, 1'b0, prot_select_otp,
		param_loc_otp, quad_default_nv, FREEZE_DEFAULT};
	assign img_cfg1_vol = {2'h0, prot_start_otp, 1'b0, prot_select_otp,
		param_loc_otp, quad, freeze};

	// Registered mode outputs
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_quad_mode <= 1'b0;
			o_qpi_mode <= 1'b0;
			o_wp_n_internal <= 1'b1;
			o_freeze <= 1'b0;
			o_bp_level <= 3'h0;
			o_program_error <= 1'b0;
		end else begin
			o_quad_mode <= quad;
			o_qpi_mode <= cfg2_vol[`VCF_CR2_QPI];
			o_wp_n_internal <= quad | wp_sync[1];
			o_freeze <= freeze;
			o_bp_level <= prot_select_otp ? bp_vol : bp_nv;
			o_program_error <= p_err;
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	sequence s_locked_area;
		area_hit && freeze;
	endsequence
	sequence s_free_area;
		area_hit && !freeze;
	endsequence

	a_lock_sticky: assert property (
		freeze && !hw_rst |=> freeze)
		else $error("lock bit cleared without hardware reset");
	a_soft_keeps_lock: assert property (
		soft_rst && !hw_rst |=> freeze == $past(freeze))
		else $error("software reset changed lock bit");
	a_locked_bp: assert property (
		freeze && !hw_rst && !soft_rst |=> $stable(bp_nv) && $stable(bp_vol)
			&& $stable({prot_start_otp, prot_select_otp, param_loc_otp}))
		else $error("locked protection bits changed");
	a_locked_otp_fail: assert property (
		s_locked_area |=> p_err ##1 o_program_error && !o_otp_program)
		else $error("locked program did not fail");
	a_free_otp_ok: assert property (
		s_free_area |=> o_otp_program ##1 !o_otp_program)
		else $error("unlocked program not requested");
	a_quad_hold: assert property (
		quad && cfg2_vol[`VCF_CR2_QPI] && !hw_rst && !soft_rst |=> quad)
		else $error("quad cleared in instruction mode");
	a_wp_ignored: assert property (
		quad |=> o_wp_n_internal)
		else $error("write protect active in quad mode");
	a_vol_quad_only: assert property (
		cfg1_vol_we |=> $stable(quad_default_nv))
		else $error("volatile write touched default");
	a_cr2_once: assert property (
		((cfg2_nv ^ CFG2_DEFAULT) & ~$past(cfg2_nv ^ CFG2_DEFAULT)) == 8'h00
			|| $past(cfg2_nv_we))
		else $error("second register changed without write");
	a_cr2_no_return: assert property (
		($past(cfg2_nv ^ CFG2_DEFAULT) & ~(cfg2_nv ^ CFG2_DEFAULT)) == 8'h00)
		else $error("second register returned to default");
	a_reserved_zero: assert property (
		img_cfg1_vol[7:6] == 2'h0 && img_cfg1_vol[4] == 1'b0
			&& img_cfg1_vol[5] == prot_start_otp)
		else $error("reserved bits not zero");

endmodule // vcf_top

`default_nettype wire

// [src/vcf_map.svh]
`ifndef VCF_MAP_SVH
`define VCF_MAP_SVH

// Serial command codes
`define VCF_CMD_WR_REGS 8'h01
`define VCF_CMD_RD_CFG 8'h35
`define VCF_CMD_RD_ANY 8'h65
`define VCF_CMD_WR_ANY 8'h71
`define VCF_CMD_AREA_PGM 8'h42

// Frame lengths in link clock edges, command byte included
`define VCF_LEN_REGS_ONE 7'h10
`define VCF_LEN_REGS_TWO 7'h18
`define VCF_LEN_ANY 7'h28
`define VCF_LEN_AREA 7'h28
`define VCF_HDR_CFG 7'h08
`define VCF_HDR_ANY 7'h20
`define VCF_ADDR_FIRST 7'h08
`define VCF_ADDR_LAST 7'h1f

// Any-register addresses
`define VCF_ADDR_STAT_NV 24'h000000
`define VCF_ADDR_CFG1_NV 24'h000002
`define VCF_ADDR_CFG2_NV 24'h000003
`define VCF_ADDR_STAT_V 24'h800000
`define VCF_ADDR_CFG1_V 24'h800002
`define VCF_ADDR_CFG2_V 24'h800003

// Field positions
`define VCF_SR_SRWD 7
`define VCF_SR_PERR 6
`define VCF_SR_BP_MSB 4
`define VCF_SR_BP_LSB 2
`define VCF_CR1_PROT_START 5
`define VCF_CR1_PROT_SEL 3
`define VCF_CR1_PARAM_LOC 2
`define VCF_CR1_QUAD 1
`define VCF_CR1_FREEZE 0
`define VCF_CR2_QPI 6
`define VCF_CR2_IO3R 5
`define VCF_CR2_MASK 8'hef

// Reset values
`define VCF_QUAD_DEF_RST 1'b0
`define VCF_FREEZE_D_RST 1'b0
`define VCF_CFG2_NV_RST 8'h08
`define VCF_BP_RST 3'h0
`define VCF_OTP_BYTES 24'h000400

`endif

// [src/vcf_pkg.sv]
package vcf_pkg;
	// One byte of register data
	typedef logic [7:0] vcf_byte_t;
	// Frame address
	typedef logic [23:0] vcf_addr_t;
	// Commands the core acts on at the end of a frame
	typedef enum {CMD_NONE, CMD_REGS, CMD_ANY, CMD_AREA} vcf_cmd_t;
endpackage

// [testbench/vcf_host.sv]
`timescale 1ns/1ps
`default_nettype none

// Host controller driving serial frames, mode 0
module vcf_host (
	// Serial link toward the device
	output logic o_link_clock,
	output logic o_cs_n,
	output logic o_si,
	// Read data back from the device
	input wire logic i_so,
	input wire logic i_so_oe
);
	// Output enable seen at the last eight rising edges
	logic [7:0] oe_last;

	// Link clock stands still low between frames
	initial begin
		o_link_clock = 1'b0;
		o_cs_n = 1'b1;
		o_si = 1'b0;
	end

	// Bits left aligned, MSB first; last 8 samples kept as read data
	task automatic frame(input logic [39:0] bits, input int n,
		output logic [7:0] rd);
		rd = 8'h00;
		oe_last = 8'h00;
		#7 o_cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			o_si = bits[39 - i];
			#40 o_link_clock = 1'b1;
			rd = {rd[6:0], i_so};
			oe_last = {oe_last[6:0], i_so_oe};
			#40 o_link_clock = 1'b0;
		end
		#40 o_cs_n = 1'b1;
		o_si = ~o_si; // Data not held once the frame ends
		#30;
	endtask
endmodule // vcf_host

`default_nettype wire

// [testbench/volatile_config_freeze_control_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module volatile_config_freeze_control_bench;
	import vcf_pkg::*;
	typedef struct packed {
		logic [39:0] bits;
		logic [5:0] n;
		logic [23:0] raddr;
		logic [7:0] exp;
		logic [2:0] bp;
	} vcf_row_t;

	logic i_clock, i_rstn, i_soft_reset, i_hw_reset_n;
	logic i_data_line_two, i_data_line_three;
	wire logic link_clock, cs_n, si, so, so_oe;
	logic quad, qpi, wp_n, freeze, perr, otp_pgm;
	logic [2:0] bp;
	vcf_addr_t otp_addr;
	vcf_byte_t otp_data, rd;
	int n_errors = 0;
	int n_tests = 0;
	int n_otp = 0;

	// Write frame (n 0 = none), then any-register read and expectations
	vcf_row_t rows [0:17] = '{
		'{40'h71800002f2, 6'd40, 24'h800002, 8'h02, 3'h0},
		'{40'h7180000200, 6'd40, 24'h800002, 8'h00, 3'h0},
		'{40'h011c000000, 6'd16, 24'h800002, 8'h00, 3'h7},
		'{40'h0100000000, 6'd17, 24'h800002, 8'h00, 3'h7},
		'{40'h0108020000, 6'd24, 24'h800002, 8'h02, 3'h2},
		'{40'h0, 6'd0, 24'h000002, 8'h02, 3'h2},
		'{40'h7180000200, 6'd40, 24'h800002, 8'h00, 3'h2},
		'{40'h0, 6'd0, 24'h000002, 8'h02, 3'h2},
		'{40'h0, 6'd0, 24'h000001, 8'h00, 3'h2},
		'{40'h7100000300, 6'd40, 24'h000003, 8'h00, 3'h2},
		'{40'h7100000308, 6'd40, 24'h000003, 8'h00, 3'h2},
		'{40'h7180000201, 6'd40, 24'h800002, 8'h01, 3'h2},
		'{40'h011c000000, 6'd16, 24'h800002, 8'h01, 3'h2},
		'{40'h7180000202, 6'd40, 24'h800002, 8'h03, 3'h2},
		'{40'h7180000348, 6'd40, 24'h800003, 8'h48, 3'h2},
		'{40'h7180000201, 6'd40, 24'h800002, 8'h03, 3'h2},
		'{40'h7180000308, 6'd40, 24'h800003, 8'h08, 3'h2},
		'{40'h7180000201, 6'd40, 24'h800002, 8'h01, 3'h2}
	};

	vcf_top DUT (
		.i_clock(i_clock), .i_rstn(i_rstn), .i_link_clock(link_clock),
		.i_cs_n(cs_n), .i_si(si), .o_so(so), .o_so_oe(so_oe),
		.i_data_line_two(i_data_line_two),
		.i_data_line_three(i_data_line_three),
		.i_hw_reset_n(i_hw_reset_n), .i_soft_reset(i_soft_reset),
		.o_quad_mode(quad), .o_qpi_mode(qpi), .o_wp_n_internal(wp_n),
		.o_freeze(freeze), .o_bp_level(bp), .o_program_error(perr),
		.o_otp_program(otp_pgm), .o_otp_addr(otp_addr),
		.o_otp_data(otp_data)
	);

	vcf_host host (
		.o_link_clock(link_clock), .o_cs_n(cs_n), .o_si(si),
		.i_so(so), .i_so_oe(so_oe)
	);

	// Core clock, 5 ns period
	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end

	// Counts accepted one-time area program pulses
	always @(posedge i_clock) begin
		if (otp_pgm === 1'b1) n_otp <= n_otp + 1;
	end

	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Core needs a few edges after chip select rises
	task automatic settle();
		repeat (8) @(negedge i_clock);
	endtask

	task automatic tally_and_finish();
		if (n_errors == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Watchdog, several times the expected run
	initial begin
		#400us;
		n_errors++;
		tally_and_finish();
	end

	initial begin
		i_rstn = 1'b0;
		i_soft_reset = 1'b0;
		i_hw_reset_n = 1'b1;
		i_data_line_two = 1'b1;
		i_data_line_three = 1'b1; // Pulled up, not driven
		repeat (12) @(negedge i_clock);
		i_rstn = 1'b1;
		settle();
		check({wp_n, freeze, quad, bp}, 6'h20);
		// Write-protect pin held active from here on
		i_data_line_two = 1'b0;
		foreach (rows[k]) begin
			if (rows[k].n != 6'd0) begin
				host.frame(rows[k].bits, int'(rows[k].n), rd);
				settle();
			end
			host.frame({8'h65, rows[k].raddr, 8'h00}, 40, rd);
			check(rd, rows[k].exp);
			check(host.oe_last, 8'hff);
			check(bp, rows[k].bp);
			check(perr, 1'b0);
			if (rows[k].raddr == 24'h800002) begin
				check({quad, freeze}, rows[k].exp[1:0]);
				check(wp_n, rows[k].exp[1]);
			end
			if (rows[k].raddr == 24'h800003) check(qpi, rows[k].exp[6]);
		end
		// Locked one-time program must fail with error
		host.frame(40'h42000010a5, 40, rd);
		settle();
		check({perr, n_otp[1:0]}, 3'h4);
		// Soft reset keeps lock, reloads quad from its default
		i_soft_reset = 1'b1;
		@(negedge i_clock);
		i_soft_reset = 1'b0;
		settle();
		host.frame(40'h3500000000, 16, rd);
		check(rd, 8'h03);
		// Hardware reset drops the lock
		i_hw_reset_n = 1'b0;
		repeat (4) @(negedge i_clock);
		i_hw_reset_n = 1'b1;
		settle();
		host.frame(40'h3500000000, 16, rd);
		check({rd, bp}, {8'h02, 3'h2});
		host.frame(40'h6580000300, 40, rd);
		check(rd, 8'h00);
		// Data line three resets in quad mode while chip select is high
		host.frame(40'h7180000203, 40, rd);
		host.frame(40'h7180000320, 40, rd);
		settle();
		check(freeze, 1'b1);
		i_data_line_three = 1'b0;
		repeat (4) @(negedge i_clock);
		i_data_line_three = 1'b1;
		settle();
		check({freeze, quad, qpi}, 3'h2);
		// Unlocked one-time program goes through
		host.frame(40'h42000010a5, 40, rd);
		settle();
		check({perr, n_otp[1:0], otp_addr, otp_data}, 35'h1000010a5);
		// Power-on reset mid-run
		i_rstn = 1'b0;
		repeat (4) @(negedge i_clock);
		i_rstn = 1'b1;
		settle();
		check({freeze, quad, wp_n}, 3'h0);
		tally_and_finish();
	end
endmodule // volatile_config_freeze_control_bench

`default_nettype wire
